// File: core/lcc_cluster.sv
// Logic cluster: control signal generation and ten logic cells.
`timescale 1ns/100ps
`default_nettype none

module lcc_cluster
    import lcc_pkg::*;
(
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Global clock lines from device pins.
    input  wire logic [NGLB-1:0]  glb_line,
    // Local routing data and control lines.
    input  wire logic [NEXT-1:0]  ext_in,
    input  wire lcc_ctl_t         ctl,
    // Register port.
    input  wire lcc_bus_t         bus,
    output logic [31:0]           rdata_r,
    // Cell outputs.
    output logic [NCELL-1:0]      cell_reg_r,
    output logic [NCELL-1:0]      cell_comb_r,
    output logic                  carry_out_r
);

    // ------------------------------------------------------------
    // Global line synchronisers
    // ------------------------------------------------------------
    logic [NGLB-1:0] gs1_r;
    logic [NGLB-1:0] gs2_r;
    logic [NGLB-1:0] gs3_r;
    logic [NGLB-1:0] glvl_r;
    logic [NGLB-1:0] glvl_nxt;
    logic [NGLB-1:0] g_agree;
    logic [NGLB-1:0] g_rise;
    logic [NGLB-1:0] g_fall;

    // A level change counts only once stages two and three agree.
    assign g_agree  = ~(gs2_r ^ gs3_r);
    assign glvl_nxt = (g_agree & gs3_r) | (~g_agree & glvl_r);
    assign g_rise   = glvl_nxt & ~glvl_r;
    assign g_fall   = ~glvl_nxt & glvl_r;

    // Three-stage capture of the global lines.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gs1_r  <= '0;
            gs2_r  <= '0;
            gs3_r  <= '0;
            glvl_r <= '0;
        end else begin
            gs1_r  <= glb_line;
            gs2_r  <= gs1_r;
            gs3_r  <= gs2_r;
            glvl_r <= glvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [CTL_W-1:0] ctrl_r;
    logic [NCELL-1:0] clksel_r;
    logic [NCELL-1:0] clrsel_r;
    logic [NCELL-1:0] mode_r;
    logic [NCELL-1:0] chain_r;
    logic [15:0]      lut_r;
    logic [31:0]      rd_mux;
    // Write decode: one strobe per writable register (none for status), all from the same port.
    wire              wr_ctrl   = bus.wr && bus.addr == OFS_CTRL;
    wire              wr_clksel = bus.wr && bus.addr == OFS_CLKSEL;
    wire              wr_clrsel = bus.wr && bus.addr == OFS_CLRSEL;
    wire              wr_mode   = bus.wr && bus.addr == OFS_MODE;
    wire              wr_chain  = bus.wr && bus.addr == OFS_CHAIN;
    wire              wr_lut    = bus.wr && bus.addr == OFS_LUT;

    // Read selection; unmapped offsets read as zero.
    assign rd_mux =
        (bus.addr == OFS_CTRL)   ? {24'h0000_00, ctrl_r} :
        (bus.addr == OFS_CLKSEL) ? {22'h00_0000, clksel_r} :
        (bus.addr == OFS_CLRSEL) ? {22'h00_0000, clrsel_r} :
        (bus.addr == OFS_MODE)   ? {22'h00_0000, mode_r} :
        (bus.addr == OFS_CHAIN)  ? {22'h00_0000, chain_r} :
        (bus.addr == OFS_LUT)    ? {16'h0000, lut_r} :
        (bus.addr == OFS_STATUS) ? {21'h00_0000, carry_out_r, cell_reg_r} :
                                   32'h0000_0000;

    // Register writes and one-cycle read data.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r   <= RST_CTRL;
            clksel_r <= RST_SEL;
            clrsel_r <= RST_SEL;
            mode_r   <= RST_SEL;
            chain_r  <= RST_SEL;
            lut_r    <= RST_LUT;
            rdata_r  <= '0;
        end else begin
            if (wr_ctrl) ctrl_r <= bus.wdata[CTL_W-1:0];
            if (wr_clksel) clksel_r <= bus.wdata[NCELL-1:0];
            if (wr_clrsel) clrsel_r <= bus.wdata[NCELL-1:0];
            if (wr_mode) mode_r <= bus.wdata[NCELL-1:0];
            if (wr_chain) chain_r <= bus.wdata[NCELL-1:0];
            if (wr_lut) lut_r <= bus.wdata[15:0];
            rdata_r <= bus.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Cluster-wide clocks and clears
    // ------------------------------------------------------------
    wire [1:0] sel_one  = ctrl_r[CTL_SEL1_LSB +: 2];
    wire [1:0] sel_two  = ctrl_r[CTL_SEL2_LSB +: 2];
    wire [1:0] sel_gclr = ctrl_r[CTL_GSEL_LSB +: 2];
    wire       dual     = ctrl_r[CTL_DUAL_BIT];
    logic      tick_one;
    logic      tick_two;
    logic      clear_one;

    // Each cluster clock fires only with its own gate high.
    assign tick_one = g_rise[sel_one] & ctl.gate_one;
    // Dual-edge use gives the falling edge to the second clock.
    assign tick_two = (dual ? g_fall[sel_one] : g_rise[sel_two])
                      & ctl.gate_two;
    // A global line may stand in as the first clear.
    assign clear_one = ctl.clear_one
                       | (ctrl_r[CTL_GCLR_BIT] & glvl_r[sel_gclr]);

    // ------------------------------------------------------------
    // Logic cells
    // ------------------------------------------------------------
    logic [NCELL:0]   carry;
    logic [NCELL:0]   lut_chain;
    logic [NCELL:0]   reg_chain;
    logic [NCELL-1:0] comb;
    logic [NCELL-1:0] cell_nxt;
    logic [NCELL-1:0] data3;

    // The lowest cell takes add/subtract as its carry-in.
    assign carry[0]     = ctl.addnsub;
    assign lut_chain[0] = 1'b0;
    assign reg_chain[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < NCELL; i = i + 1) begin : g_cell
            wire a = ext_in[i];
            wire b = ext_in[NCELL + i];
            wire bx;
            wire sum;
            wire lut_o;
            wire tick;
            wire aclr;
            wire dsrc;
            // Extra inputs cover six cells; the rest use local feedback.
            if (i < NDATA3) begin : g_ext
                assign data3[i] = ext_in[2 * NCELL + i];
            end else begin : g_fb
                assign data3[i] = cell_reg_r[i];
            end
            // Subtract inverts the second operand.
            assign bx    = b ^ ctl.addnsub;
            assign sum   = a ^ bx ^ carry[i];
            assign carry[i + 1] = (a & bx) | (carry[i] & (a ^ bx));
            assign lut_o = lut_r[{lut_chain[i], data3[i], b, a}];
            assign comb[i] = mode_r[i] ? sum : lut_o;
            assign lut_chain[i + 1] = comb[i];
            assign reg_chain[i + 1] = cell_reg_r[i];
            assign tick  = clksel_r[i] ? tick_two : tick_one;
            assign aclr  = clrsel_r[i] ? ctl.clear_two : clear_one;
            assign dsrc  = chain_r[i] ? reg_chain[i] : comb[i];
            // Clear, then load/preset, then clocked actions.
            assign cell_nxt[i] =
                aclr      ? 1'b0 :
                ctl.aload ? data3[i] :
                !tick     ? cell_reg_r[i] :
                ctl.sclr  ? 1'b0 :
                ctl.sload ? a : dsrc;
        end
    endgenerate

    // Cell registers and registered combinational outputs.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cell_reg_r  <= '0;
            cell_comb_r <= '0;
            carry_out_r <= 1'b0;
        end else begin
            cell_reg_r  <= cell_nxt;
            cell_comb_r <= comb;
            carry_out_r <= carry[NCELL];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Cell 0 stands for the cells on the first cluster clock.
    wire c0_free = !clear_one && !clrsel_r[0] && !ctl.aload;
    wire c0_tick = !clksel_r[0] && tick_one;
    // Cell 5 stands for the cells on the second cluster clock.
    wire c5_free = !clrsel_r[5] && !clear_one && !ctl.aload;

    a_clear_over_load: assert property (
        (clear_one && !clrsel_r[0] && ctl.aload) |=> !cell_reg_r[0])
        else $error("clear did not beat asynchronous load");

    a_second_clear: assert property (
        (ctl.clear_two && clrsel_r[5]) ##1 (ctl.clear_two && clrsel_r[5])
        |=> !cell_reg_r[5] && !$past(cell_reg_r[5]))
        else $error("second clear failed to hold cell low");

    a_preset_high: assert property (
        !clear_one && !clrsel_r[0]
        && ctl.aload && data3[0] |=> cell_reg_r[0])
        else $error("preset did not set cell high");

    a_gate_holds: assert property (
        (c0_free && !clksel_r[0] && !ctl.gate_one)
        |=> $stable(cell_reg_r[0]))
        else $error("cell changed with its clock gated");

    a_gate_two_holds: assert property (
        (c5_free && clksel_r[5] && !ctl.gate_two) |=> $stable(cell_reg_r[5]))
        else $error("second-clock cell changed with its gate low");

    a_sync_clear: assert property (
        (c0_free && c0_tick && ctl.sclr) |=> !cell_reg_r[0])
        else $error("synchronous clear missed");

    a_sync_load: assert property (
        (c0_free && c0_tick && !ctl.sclr && ctl.sload)
        |=> cell_reg_r[0] == $past(ext_in[0]))
        else $error("synchronous load missed");

    a_subtract_op: assert property (
        (c0_free && c0_tick && !ctl.sclr && !ctl.sload && mode_r[0]
         && !chain_r[0] && ctl.addnsub)
        |=> cell_reg_r[0] == $past(ext_in[0] ^ ext_in[NCELL]))
        else $error("subtract result wrong in lowest cell");

    a_reg_chain: assert property (
        (!clear_one && !clrsel_r[1] && !ctl.aload && !clksel_r[1]
         && tick_one && !ctl.sclr && !ctl.sload && chain_r[1])
        |=> cell_reg_r[1] == $past(cell_reg_r[0]))
        else $error("register chain did not shift");

    a_dual_edge: assert property (
        (dual && $fell(glvl_r[sel_one]) && $past(ctl.gate_two)
         && $stable(ctrl_r))
        |-> $past(tick_two) && !$past(tick_one))
        else $error("falling edge not given to second clock");

    // A pin glitch shorter than two samples must never reach the level.
    a_sync_lag: assert property (
        $rose(glvl_r[0]) |-> $past(gs2_r[0]) && $past(gs3_r[0]))
        else $error("global level changed before stages agreed");

    a_lut_cell: assert property (
        !mode_r[0] |=> cell_comb_r[0]
            == $past(lut_r[{1'b0, data3[0], ext_in[NCELL], ext_in[0]}]))
        else $error("lookup output of first cell wrong");

    a_lut_chain: assert property (
        !mode_r[1] |=> cell_comb_r[1]
            == $past(lut_r[{comb[0], data3[1], ext_in[NCELL + 1], ext_in[1]}]))
        else $error("lookup chain into second cell wrong");

    a_rdata_idle: assert property (
        !bus.rd |=> rdata_r == 32'h0000_0000)
        else $error("read data outside the read cycle");

    c_tick_one:  cover property (tick_one && ctl.gate_one);
    c_dual_edge: cover property (dual && tick_two);
    c_subtract:  cover property (c0_tick && mode_r[0] && ctl.addnsub);
    c_preset:    cover property (ctl.aload && data3[0]);
    c_sync_clear: cover property (c0_tick && ctl.sclr);

endmodule

`default_nettype wire

// File: pkg/lcc_pkg.sv
// Shared constants and types for the logic cluster control block.
package lcc_pkg;

    // ------------------------------------------------------------
    // Structure sizes
    // ------------------------------------------------------------
    localparam int NCELL = 10;
    localparam int NGLB  = 4;
    localparam int NEXT  = 26;
    localparam int NDATA3 = NEXT - 2 * NCELL;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_CLKSEL = 5'h04;
    localparam logic [4:0] OFS_CLRSEL = 5'h08;
    localparam logic [4:0] OFS_MODE   = 5'h0C;
    localparam logic [4:0] OFS_CHAIN  = 5'h10;
    localparam logic [4:0] OFS_LUT    = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTL_SEL1_LSB = 0;
    localparam int CTL_SEL2_LSB = 2;
    localparam int CTL_DUAL_BIT = 4;
    localparam int CTL_GCLR_BIT = 5;
    localparam int CTL_GSEL_LSB = 6;
    localparam int CTL_W        = 8;
    localparam logic [7:0]  RST_CTRL = 8'h00;
    localparam logic [9:0]  RST_SEL  = 10'h000;
    localparam logic [15:0] RST_LUT  = 16'h0000;

    // Cluster-wide control lines from local routing.
    typedef struct packed {
        logic gate_one;
        logic gate_two;
        logic clear_one;
        logic clear_two;
        logic aload;
        logic sclr;
        logic sload;
        logic addnsub;
    } lcc_ctl_t;

    // Register port request.
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lcc_bus_t;

endpackage

// File: verification/lcc_cluster_bench.sv
// Self-checking bench for the logic cluster control block.
`timescale 1ns/100ps
`default_nettype none

module lcc_cluster_bench
    import lcc_pkg::*;
();
    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    logic             mclk;
    logic             rst_n;
    logic [NGLB-1:0]  glb_line;
    logic [NEXT-1:0]  ext_in;
    lcc_ctl_t         ctl;
    lcc_bus_t         bus;
    logic [31:0]      rdata_r;
    logic [NCELL-1:0] cell_reg_r;
    logic [NCELL-1:0] cell_comb_r;
    logic             carry_out_r;
    logic [10:0]      sum_exp;
    int               fail_count;
    int               compares;

    lcc_cluster i_lcc_cluster (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .glb_line    (glb_line),
        .ext_in      (ext_in),
        .ctl         (ctl),
        .bus         (bus),
        .rdata_r     (rdata_r),
        .cell_reg_r  (cell_reg_r),
        .cell_comb_r (cell_comb_r),
        .carry_out_r (carry_out_r)
    );

    // Free-running 25 MHz clock.
    always #20 mclk = ~mclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write.
    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge mclk);
        bus.wr    <= 1'b0;
    endtask

    // One-cycle register read; data are judged in the following cycle.
    task automatic reg_rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge mclk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge mclk);
        bus.rd   <= 1'b0;
        #1 check("read data", exp, rdata_r);
    endtask

    // Sets the control lines and the routing data after an edge.
    task automatic drive(input logic [7:0] c, input logic [NEXT-1:0] d);
        @(posedge mclk);
        ctl    <= lcc_ctl_t'(c);
        ext_in <= d;
    endtask

    // One clean pulse on a global line, long enough to pass the sync.
    task automatic pulse(input int line);
        @(posedge mclk);
        glb_line[line] <= 1'b1;
        repeat (6) @(posedge mclk);
        glb_line[line] <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    // Loads every cell from its a input with clock one on line 0.
    task automatic load_all(input logic [9:0] a);
        drive(8'h82, {16'h0000, a});
        pulse(0);
        #1 check("cell load", {22'h0, a}, {22'h0, cell_reg_r});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, read-only status and unmapped places.
    task automatic t_regs();
        reg_rd(OFS_CTRL, 32'h0000_0000);
        reg_rd(OFS_STATUS, 32'h0000_0000);
        reg_wr(OFS_LUT, 32'hFFFF_A5C3);
        reg_rd(OFS_LUT, 32'h0000_A5C3);
        reg_wr(OFS_STATUS, 32'h0000_07FF);
        reg_rd(OFS_STATUS, 32'h0000_0000);
        reg_wr(5'h1C, 32'h1234_5678);
        reg_rd(5'h1C, 32'h0000_0000);
        reg_rd(OFS_LUT, 32'h0000_A5C3);
        @(posedge mclk);
        #1 check("idle read data", 32'h0, rdata_r);
    endtask

    // Gate low drops the edge; the clock line is selectable.
    task automatic t_gate();
        drive(8'h02, {16'h0000, 10'h155});
        pulse(0);
        #1 check("gated off", 32'h0, {22'h0, cell_reg_r});
        load_all(10'h155);
        reg_wr(OFS_CTRL, 32'h0000_0002);
        drive(8'h82, {16'h0000, 10'h0AA});
        pulse(0);
        #1 check("other line", 32'h155, {22'h0, cell_reg_r});
        pulse(2);
        #1 check("line two", 32'h0AA, {22'h0, cell_reg_r});
        reg_wr(OFS_CTRL, 32'h0000_0000);
    endtask

    // Add and subtract through the whole cluster with carry out.
    task automatic t_arith();
        reg_wr(OFS_MODE, 32'h0000_03FF);
        for (int s = 0; s < 2; s++) begin
            drive(8'h80 | 8'(s), {6'h00, 10'h1C3, 10'h2A5});
            pulse(0);
            sum_exp = 11'h2A5 + {1'b0, 10'h1C3 ^ {10{s[0]}}} + 11'(s);
            #1 check("sum", 32'(sum_exp), {21'h0, carry_out_r, cell_reg_r});
            reg_rd(OFS_STATUS, 32'(sum_exp));
        end
        reg_wr(OFS_MODE, 32'h0000_0000);
    endtask

    // Register chain shifts each cell into the next one.
    task automatic t_chain();
        load_all(10'h2D1);
        reg_wr(OFS_CHAIN, 32'h0000_03FF);
        drive(8'h80, '0);
        pulse(0);
        #1 check("chain", 32'h1A2, {22'h0, cell_reg_r});
        reg_wr(OFS_CHAIN, 32'h0000_0000);
    endtask

    // Lookup chain between cells and the data3 source of each cell.
    task automatic t_lut();
        load_all(10'h2C0);
        reg_wr(OFS_LUT, 32'h0000_FFAA);
        drive(8'h00, {16'h0000, 10'h008});
        @(posedge mclk);
        #1 check("lut chain", 32'h3F8, {22'h0, cell_comb_r});
        reg_wr(OFS_LUT, 32'h0000_F0F0);
        drive(8'h00, {6'h15, 20'h0_0000});
        @(posedge mclk);
        #1 check("data3 source", 32'h2D5, {22'h0, cell_comb_r});
    endtask

    // Second cluster clock, its gate, dual-edge use and synchronous clear.
    task automatic t_clk_two();
        load_all(10'h3FF);
        reg_wr(OFS_CLKSEL, 32'h0000_03E0);
        reg_wr(OFS_CTRL, 32'h0000_0004);
        drive(8'h44, '0);
        pulse(0);
        #1 check("clock one gated", 32'h3FF, {22'h0, cell_reg_r});
        pulse(1);
        #1 check("sync clear two", 32'h01F, {22'h0, cell_reg_r});
        reg_wr(OFS_CTRL, 32'h0000_0010);
        drive(8'h42, {16'h0000, 10'h2B4});
        @(posedge mclk);
        glb_line[0] <= 1'b1;
        repeat (6) @(posedge mclk);
        glb_line[0] <= 1'b0;
        #1 check("rise skips two", 32'h01F, {22'h0, cell_reg_r});
        repeat (6) @(posedge mclk);
        #1 check("fall clocks two", 32'h2BF, {22'h0, cell_reg_r});
        drive(8'h84, '0);
        pulse(0);
        #1 check("sync clear one", 32'h2A0, {22'h0, cell_reg_r});
        reg_wr(OFS_CTRL, 32'h0000_0000);
        reg_wr(OFS_CLKSEL, 32'h0000_0000);
        drive(8'h00, '0);
    endtask

    // Two clears, preset by load, and clear over load.
    task automatic t_clear();
        load_all(10'h3FF);
        reg_wr(OFS_CLRSEL, 32'h0000_03E0);
        drive(8'h10, '0);
        repeat (2) @(posedge mclk);
        #1 check("clear two", 32'h01F, {22'h0, cell_reg_r});
        drive(8'h08, {6'h3F, 20'h0_0000});
        repeat (2) @(posedge mclk);
        #1 check("preset", 32'h03F, {22'h0, cell_reg_r});
        drive(8'h28, {6'h3F, 20'h0_0000});
        repeat (2) @(posedge mclk);
        #1 check("clear wins", 32'h020, {22'h0, cell_reg_r});
        drive(8'h00, '0);
        reg_wr(OFS_CLRSEL, 32'h0000_0000);
    endtask

    // Global line 3 used as a clear.
    task automatic t_glclr();
        load_all(10'h3FF);
        reg_wr(OFS_CTRL, 32'h0000_00E0);
        @(posedge mclk);
        glb_line[3] <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 check("global clear", 32'h0, {22'h0, cell_reg_r});
        @(posedge mclk);
        glb_line[3] <= 1'b0;
        reg_wr(OFS_CTRL, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk       = 1'b0;
        rst_n      = 1'b0;
        glb_line   = '0;
        ext_in     = '0;
        ctl        = '0;
        bus        = '0;
        fail_count = 0;
        compares   = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_gate();
        t_arith();
        t_chain();
        t_lut();
        t_clear();
        t_glclr();
        t_clk_two();
        give_verdict();
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #(40 * 20000);
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
